// ===== sie_params.svh
`ifndef SIE_PARAMS_SVH
`define SIE_PARAMS_SVH

// Clock cycles per instruction cycle.
`define SIE_CYC_DIV 4
// Instruction cycles an input line must stay low before its edge latch sets.
`define SIE_EDGE_HOLD 2
// Program counter width and return stack depth.
`define SIE_PC_W 11
`define SIE_STACK_DEPTH 3
// Single-byte opcodes.
`define SIE_OP_CLEAR_ACC 8'h00
`define SIE_OP_EXCHANGE 8'h4f
`define SIE_OP_TIMER_SKIP 8'h41
`define SIE_OP_IDLE 8'h39
`define SIE_OP_PREFIX 8'h33
`define SIE_OP_JUMP_IND 8'hff
`define SIE_OP_TABLE_IND 8'hbf
// Second bytes after the prefix.
`define SIE_OP2_READ_EDGE 8'h29
`define SIE_OP2_LOAD_TIMER 8'h3f
// Top bits selecting the in-page jump and the page-two call.
`define SIE_PAGE_JUMP_TOP 2'b11
`define SIE_CALL_TOP 2'b10
// Page index of the subroutine page.
`define SIE_CALL_PAGE 5'h02
// Timer all-ones value and zero value.
`define SIE_TIMER_MAX 8'hff
`define SIE_TIMER_ZERO 8'h00

`endif

// ===== sie_pkg.sv
`default_nettype none

package sie_pkg;
    // Execution phases of the instruction sequencer.
    typedef enum logic [1:0] {
        SIE_FETCH,
        SIE_SECOND,
        SIE_INDIRECT,
        SIE_IDLE
    } sie_state_t;
endpackage

`default_nettype wire

// ===== sie_edge_latch.sv
`include "sie_params.svh"
`default_nettype none

module sie_edge_latch #(
    parameter int HOLD = `SIE_EDGE_HOLD
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic tick_i,
    input wire logic line_i,
    input wire logic clear_i,
    output logic latch_o
);
    logic sync1_q;
    logic sync2_q;
    logic armed_q;
    logic [3:0] low_cnt_q;
    logic hit;

    // Two-stage synchroniser; the line is asynchronous to the core.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
        end else begin
            sync1_q <= line_i;
            sync2_q <= sync1_q;
        end
    end

    // A pulse counts only after the line was seen high, so a line held low
    // through reset does not fake a falling edge.
    assign hit = tick_i && armed_q && !sync2_q && (low_cnt_q == 4'(HOLD - 1));

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            armed_q <= 1'b0;
            low_cnt_q <= 4'h0;
        end else if (tick_i) begin
            if (sync2_q) begin
                armed_q <= 1'b1;
                low_cnt_q <= 4'h0;
            end else if (hit) begin
                armed_q <= 1'b0;
                low_cnt_q <= 4'h0;
            end else if (armed_q) begin
                low_cnt_q <= low_cnt_q + 4'h1;
            end
        end
    end

    // Set wins over the clear from a read in the same cycle.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            latch_o <= 1'b0;
        end else if (hit) begin
            latch_o <= 1'b1;
        end else if (clear_i) begin
            latch_o <= 1'b0;
        end
    end
endmodule

`default_nettype wire

// ===== sie_timer.sv
`include "sie_params.svh"
`default_nettype none

module sie_timer #(
    parameter int WIDTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic tick_i,
    input wire logic ext_mode_i,
    input wire logic ext_fall_i,
    input wire logic load_i,
    input wire logic [WIDTH-1:0] load_val_i,
    output logic [WIDTH-1:0] count_o,
    output logic ovf_o
);
    logic step;

    // Counts instruction cycles, or external falling edges in event mode.
    // It keeps running while the core idles, which is what wakes it.
    assign step = ext_mode_i ? ext_fall_i : tick_i;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            count_o <= '0;
            ovf_o <= 1'b0;
        end else begin
            ovf_o <= 1'b0;
            if (load_i) begin
                count_o <= load_val_i;
            end else if (step) begin
                count_o <= count_o + 1'b1;
                ovf_o <= &count_o;
            end
        end
    end
endmodule

`default_nettype wire

// ===== sie_core.sv
`include "sie_params.svh"
`default_nettype none

module sie_core #(
    parameter int CYC_DIV = `SIE_CYC_DIV,
    parameter int PC_W = `SIE_PC_W
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    output logic [PC_W-1:0] pm_addr_o,
    input wire logic [7:0] pm_data_i,
    input wire logic carry_i,
    input wire logic [3:0] ram_digit_i,
    input wire logic serial_mode_counter_i,
    input wire logic serial_in_i,
    input wire logic input_line_three_i,
    input wire logic input_line_zero_i,
    input wire logic clock_out_input_pin_i,
    input wire logic timer_source_select_pin_i,
    input wire logic timer_event_i,
    output logic [3:0] acc_o,
    output logic [3:0] serial_shift_counter_o,
    output logic [7:0] lookup_latch_o,
    output logic serial_clock_latch_o,
    output logic serial_out_o,
    output logic skip_o,
    output logic timer_ovf_latch_o,
    output logic edge_latch_three_o,
    output logic edge_latch_zero_o,
    output logic [7:0] timer_count_o,
    output sie_pkg::sie_state_t state_o
);
    import sie_pkg::*;

    logic [$clog2(CYC_DIV)-1:0] div_q;
    logic tick;
    logic [7:0] pm_s1_q;
    logic [7:0] pm_s2_q;
    logic [3:0] si_s1_q;
    logic [3:0] si_s2_q;
    logic si_prev_q;
    logic ev_prev_q;
    logic [PC_W-1:0] stack_level_one_q;
    logic [PC_W-1:0] stack_level_two_q;
    logic [PC_W-1:0] stack_level_three_q;
    logic table_mode_q;
    logic [PC_W-1:0] pcn;
    logic [PC_W-1:0] indirect_addr;
    logic in_fetch;
    logic in_second;
    logic is_exch;
    logic is_tskip;
    logic is_jump_ind;
    logic is_table_ind;
    logic is_idle;
    logic is_page_jump;
    logic is_call;
    logic is_clear_acc;
    logic is_edge_read;
    logic is_timer_load;
    logic edge_clear;
    logic timer_load;
    logic timer_ovf;
    logic ext_fall;
    logic si_fall;

    // Instruction-cycle enable; all but the synchronisers, event-edge history, event-mode timer, overflow latch and idle wake-up move on it.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            div_q <= '0;
        end else if (div_q == ($clog2(CYC_DIV))'(CYC_DIV - 1)) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end
    assign tick = (div_q == ($clog2(CYC_DIV))'(CYC_DIV - 1));

    // Pin synchronisers. Memory data must settle within two clocks of an address change,
    // so the two-stage delay still fits before the tick that uses it.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pm_s1_q <= 8'h00;
            pm_s2_q <= 8'h00;
            si_s1_q <= 4'h0;
            si_s2_q <= 4'h0;
        end else begin
            pm_s1_q <= pm_data_i;
            pm_s2_q <= pm_s1_q;
            si_s1_q <= {timer_source_select_pin_i, timer_event_i, clock_out_input_pin_i,
                        serial_in_i};
            si_s2_q <= si_s1_q;
        end
    end

    // Edge history for the serial counter input and the external timer event.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            si_prev_q <= 1'b0;
            ev_prev_q <= 1'b0;
        end else begin
            ev_prev_q <= si_s2_q[2];
            if (tick) begin
                si_prev_q <= si_s2_q[0];
            end
        end
    end
    assign ext_fall = ev_prev_q && !si_s2_q[2];
    assign si_fall = tick && si_prev_q && !si_s2_q[0];

    // Decode of the byte just arrived for the current address.
    assign in_fetch = tick && (state_o == SIE_FETCH);
    assign in_second = tick && (state_o == SIE_SECOND);
    assign pcn = pm_addr_o + 1'b1;
    assign indirect_addr = {pcn[PC_W-1:8], acc_o, ram_digit_i};
    assign is_clear_acc = (pm_s2_q == `SIE_OP_CLEAR_ACC);
    assign is_exch = (pm_s2_q == `SIE_OP_EXCHANGE);
    assign is_tskip = (pm_s2_q == `SIE_OP_TIMER_SKIP);
    assign is_idle = (pm_s2_q == `SIE_OP_IDLE);
    assign is_jump_ind = (pm_s2_q == `SIE_OP_JUMP_IND);
    assign is_table_ind = (pm_s2_q == `SIE_OP_TABLE_IND);
    assign is_page_jump = (pm_s2_q[7:6] == `SIE_PAGE_JUMP_TOP) && !is_jump_ind;
    assign is_call = (pm_s2_q[7:6] == `SIE_CALL_TOP) && !is_table_ind;
    assign is_edge_read = (pm_s2_q == `SIE_OP2_READ_EDGE);
    assign is_timer_load = (pm_s2_q == `SIE_OP2_LOAD_TIMER);
    assign edge_clear = in_second && !skip_o && is_edge_read;
    assign timer_load = in_second && !skip_o && is_timer_load;

    // Sequencer: state and program counter.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_o <= SIE_FETCH;
            pm_addr_o <= '0;
            table_mode_q <= 1'b0;
        end else if (tick) begin
            case (state_o)
                SIE_FETCH: begin
                    pm_addr_o <= pcn;
                    if (pm_s2_q == `SIE_OP_PREFIX) begin
                        state_o <= SIE_SECOND;
                    end else if (skip_o) begin
                        state_o <= SIE_FETCH;
                    end else if (is_jump_ind || is_table_ind) begin
                        pm_addr_o <= indirect_addr;
                        table_mode_q <= is_table_ind;
                        state_o <= SIE_INDIRECT;
                    end else if (is_page_jump) begin
                        pm_addr_o <= {pcn[PC_W-1:6], pm_s2_q[5:0]};
                    end else if (is_call) begin
                        pm_addr_o <= {(PC_W-6)'(`SIE_CALL_PAGE), pm_s2_q[5:0]};
                    end else if (is_idle) begin
                        state_o <= SIE_IDLE;
                    end
                end
                SIE_SECOND: begin
                    pm_addr_o <= pcn;
                    state_o <= SIE_FETCH;
                end
                SIE_INDIRECT: begin
                    state_o <= SIE_FETCH;
                    if (table_mode_q) begin
                        pm_addr_o <= stack_level_one_q;
                    end else begin
                        pm_addr_o <= {pm_addr_o[PC_W-1:8], pm_s2_q};
                    end
                end
                SIE_IDLE: begin
                    if (timer_ovf) begin
                        state_o <= SIE_FETCH;
                    end
                end
                default: begin
                    state_o <= SIE_FETCH;
                end
            endcase
        end else if (state_o == SIE_IDLE && timer_ovf) begin
            state_o <= SIE_FETCH;
        end
    end

    // Three-level return stack; a push drops the deepest entry.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            stack_level_one_q <= '0;
            stack_level_two_q <= '0;
            stack_level_three_q <= '0;
        end else if (in_fetch && !skip_o && (is_table_ind || is_call)) begin
            stack_level_one_q <= pcn;
            stack_level_two_q <= stack_level_one_q;
            stack_level_three_q <= stack_level_two_q;
        end else if (tick && state_o == SIE_INDIRECT && table_mode_q) begin
            stack_level_one_q <= stack_level_two_q;
            stack_level_two_q <= stack_level_three_q;
        end
    end

    // Skip flag covers one whole instruction, both bytes of a prefixed one.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            skip_o <= 1'b0;
        end else if (in_fetch) begin
            if (skip_o) begin
                skip_o <= (pm_s2_q == `SIE_OP_PREFIX);
            end else begin
                skip_o <= is_tskip && timer_ovf_latch_o;
            end
        end else if (in_second) begin
            skip_o <= 1'b0;
        end
    end

    // Overflow latch; a new overflow wins over the clear from a test.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            timer_ovf_latch_o <= 1'b0;
        end else if (timer_ovf) begin
            timer_ovf_latch_o <= 1'b1;
        end else if (timer_load && acc_o[3]) begin
            timer_ovf_latch_o <= 1'b1;
        end else if (in_fetch && !skip_o && is_tskip) begin
            timer_ovf_latch_o <= 1'b0;
        end
    end

    // Accumulator writers; kept apart so that only the exchange stalls the serial register.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            acc_o <= 4'h0;
        end else if (in_fetch && !skip_o && is_exch) begin
            acc_o <= serial_shift_counter_o;
        end else if (in_fetch && !skip_o && is_clear_acc) begin
            acc_o <= 4'h0;
        end else if (edge_clear) begin
            acc_o <= {edge_latch_three_o, si_s2_q[1], 1'b0, edge_latch_zero_o};
        end
    end

    // Serial register and clock latch. An exchange overrides the shift or
    // count of the same cycle; no other instruction holds the stream up.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            serial_shift_counter_o <= 4'h0;
            serial_clock_latch_o <= 1'b0;
        end else if (in_fetch && !skip_o && is_exch) begin
            serial_shift_counter_o <= acc_o;
            serial_clock_latch_o <= carry_i;
        end else if (tick && serial_mode_counter_i) begin
            if (si_fall) begin
                serial_shift_counter_o <= serial_shift_counter_o + 4'h1;
            end
        end else if (tick && serial_clock_latch_o) begin
            serial_shift_counter_o <= {serial_shift_counter_o[2:0], si_s2_q[0]};
        end
    end

    // Serial data leaves from the top bit, one bit per instruction cycle.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            serial_out_o <= 1'b0;
        end else if (tick && !serial_mode_counter_i) begin
            serial_out_o <= serial_shift_counter_o[3];
        end
    end

    // Lookup latch loaded in the second cycle of a table load.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            lookup_latch_o <= 8'h00;
        end else if (tick && state_o == SIE_INDIRECT && table_mode_q) begin
            lookup_latch_o <= pm_s2_q;
        end
    end

    // Two edge latches built from one parameterised cell.
    sie_edge_latch #(
        .HOLD(`SIE_EDGE_HOLD)
    ) u_edge_three (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .tick_i(tick),
        .line_i(input_line_three_i),
        .clear_i(edge_clear),
        .latch_o(edge_latch_three_o)
    );

    sie_edge_latch #(
        .HOLD(`SIE_EDGE_HOLD)
    ) u_edge_zero (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .tick_i(tick),
        .line_i(input_line_zero_i),
        .clear_i(edge_clear),
        .latch_o(edge_latch_zero_o)
    );

    // Timer keeps counting while the sequencer idles. Event mode must not be
    // combined with idle, since the wake-up then hangs on external events.
    sie_timer #(
        .WIDTH(8)
    ) u_timer (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .tick_i(tick),
        .ext_mode_i(si_s2_q[3]),
        .ext_fall_i(ext_fall),
        .load_i(timer_load),
        .load_val_i({acc_o, ram_digit_i}),
        .count_o(timer_count_o),
        .ovf_o(timer_ovf)
    );
endmodule

`default_nettype wire

// ===== sie_core_assertions.sv
`default_nettype none

module sie_core_chk #(
    parameter int PC_W = 11
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [PC_W-1:0] pm_addr_o,
    input wire logic carry_i,
    input wire logic [3:0] acc_o,
    input wire logic [3:0] serial_shift_counter_o,
    input wire logic serial_clock_latch_o,
    input wire logic skip_o,
    input wire logic timer_ovf_latch_o,
    input wire logic edge_latch_three_o,
    input wire logic edge_latch_zero_o,
    input wire logic [7:0] timer_count_o,
    input wire sie_pkg::sie_state_t state_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import sie_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // Idle steps: held for two samples, or just left.
    sequence s_idle_kept;
        (state_o == SIE_IDLE) ##1 (state_o == SIE_IDLE);
    endsequence
    sequence s_idle_left;
        (state_o == SIE_IDLE) ##1 (state_o != SIE_IDLE);
    endsequence

    // An address change starts a full four-clock instruction cycle.
    chk_addr_stands: assert property ($changed(pm_addr_o) |=> $stable(pm_addr_o) [*3])
        else $error("address moved inside an instruction cycle");
    chk_swap_done: assert property ($rose(serial_clock_latch_o) |-> $past(carry_i) &&
        acc_o == $past(serial_shift_counter_o) && serial_shift_counter_o == $past(acc_o))
        else $error("exchange did not swap or copy carry");
    chk_read_three: assert property ($fell(edge_latch_three_o) |-> acc_o[3] && !acc_o[1])
        else $error("edge read packed latch three wrongly");
    chk_read_zero: assert property ($fell(edge_latch_zero_o) |-> acc_o[0] && !acc_o[1])
        else $error("edge read packed latch zero wrongly");
    chk_reset_clears: assert property (disable iff (1'b0) !rst_n_i |=>
        !edge_latch_three_o && !edge_latch_zero_o)
        else $error("reset left an edge latch set");
    chk_ovf_skips: assert property ($fell(timer_ovf_latch_o) |-> skip_o)
        else $error("overflow latch cleared without a skip");
    chk_skip_whole: assert property ($rose(skip_o) |-> skip_o [*4])
        else $error("skip shorter than one instruction cycle");
    chk_ovf_cause: assert property ($rose(timer_ovf_latch_o) |->
        timer_count_o[7] || timer_count_o == 8'h00)
        else $error("overflow latch set without a cause");
    chk_idle_halts: assert property (s_idle_kept |-> $stable(pm_addr_o))
        else $error("address moved while idle");
    chk_idle_wakes: assert property (s_idle_left |-> timer_count_o == 8'h00)
        else $error("idle left without timer overflow");
endmodule

bind sie_core sie_core_chk #(.PC_W(PC_W)) u_chk (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .pm_addr_o(pm_addr_o), .carry_i(carry_i),
    .acc_o(acc_o), .serial_shift_counter_o(serial_shift_counter_o),
    .serial_clock_latch_o(serial_clock_latch_o), .skip_o(skip_o),
    .timer_ovf_latch_o(timer_ovf_latch_o), .edge_latch_three_o(edge_latch_three_o),
    .edge_latch_zero_o(edge_latch_zero_o), .timer_count_o(timer_count_o), .state_o(state_o)
);

`default_nettype wire

// ===== sie_prog_mem.sv
`default_nettype none

module sie_prog_mem (
    input wire logic [10:0] addr_i,
    output logic [7:0] data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] words [2048];

    // Test program; every unlisted word is the clear-accumulator opcode.
    initial begin
        foreach (words[i]) words[i] = 8'h00;
        words[11'h000] = 8'h00;
        words[11'h004] = 8'h33;
        words[11'h005] = 8'h29;
        words[11'h006] = 8'hbf;
        words[11'h007] = 8'h33;
        words[11'h008] = 8'h3f;
        words[11'h009] = 8'h41;
        words[11'h00a] = 8'hbf;
        words[11'h00b] = 8'h41;
        words[11'h00c] = 8'hff;
        words[11'h0c5] = 8'ha7;
        words[11'h0a7] = 8'h4f;
        words[11'h0a8] = 8'h39;
        words[11'h0a9] = 8'hfe;
        words[11'h0bf] = 8'hfe;
        words[11'h0ff] = 8'hff;
        words[11'h105] = 8'h30;
    end

    // Answers at once, well inside the two-clock settling allowance.
    assign data_o = words[addr_i];
endmodule

`default_nettype wire

// ===== tb_selected_instruction_execution.sv
`default_nettype none

module tb_selected_instruction_execution;
    timeunit 1ns;
    timeprecision 1ps;
    import sie_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic carry = 1'b0;
    logic cmode = 1'b0;
    logic sin = 1'b0;
    logic tsel = 1'b0;
    logic tev = 1'b1;
    logic [7:0] tcnt;
    logic [3:0] ram = 4'h0;
    logic line3 = 1'b1;
    logic line0 = 1'b1;
    logic [10:0] addr;
    logic [7:0] data, lookup;
    logic [3:0] acc, ser;
    logic sclk, skip, ovf, el3, el0, sout;
    sie_state_t state;
    int error_cnt = 0;
    int n_checks = 0;
    int n;

    // Timer counts instruction cycles until the last test, so idle is allowed.
    sie_core dut (
        .clk_i(clk), .rst_n_i(rst_n), .pm_addr_o(addr), .pm_data_i(data), .carry_i(carry),
        .ram_digit_i(ram), .serial_mode_counter_i(cmode), .serial_in_i(sin),
        .input_line_three_i(line3), .input_line_zero_i(line0), .clock_out_input_pin_i(1'b1),
        .timer_source_select_pin_i(tsel), .timer_event_i(tev), .acc_o(acc),
        .serial_shift_counter_o(ser), .lookup_latch_o(lookup), .serial_clock_latch_o(sclk),
        .serial_out_o(sout), .skip_o(skip), .timer_ovf_latch_o(ovf), .edge_latch_three_o(el3),
        .edge_latch_zero_o(el0), .timer_count_o(tcnt), .state_o(state)
    );
    sie_prog_mem u_mem (.addr_i(addr), .data_o(data));

    // Clock of 50 MHz.
    always #10 clk = ~clk;

    task automatic chk_v(input string what, input logic [10:0] exp, input logic [10:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_st(input string what, input sie_state_t exp, input sie_state_t got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    // Waits whole instruction cycles and lands on a falling edge to drive.
    task automatic cyc(input int k);
        repeat (4 * k) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic end_test(input string name);
        $display("test %s done", name);
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // The whole program needs well under a thousand clocks.
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        $display("ERROR watchdog expected finish seen hang");
        stop_test();
    end

    // Test sequence; each step checks at a falling edge inside a cycle.
    initial begin
        repeat (5) @(negedge clk);
        chk_v("latch three", 11'h0, 11'(el3));
        chk_v("latch zero", 11'h0, 11'(el0));
        rst_n = 1'b1;
        end_test("reset");
        cyc(1);
        line3 = 1'b0;
        line0 = 1'b0;
        cyc(1);
        line0 = 1'b1;
        cyc(2);
        line3 = 1'b1;
        chk_v("latch three", 11'h1, 11'(el3));
        chk_v("latch zero", 11'h0, 11'(el0));
        ram = 4'h5;
        cyc(2);
        chk_v("edge read acc", 11'h00c, 11'(acc));
        chk_v("latch three", 11'h0, 11'(el3));
        end_test("edge");
        cyc(1);
        chk_v("table address", 11'h0c5, addr);
        cyc(1);
        chk_v("lookup latch", 11'h0a7, 11'(lookup));
        chk_v("return address", 11'h007, addr);
        end_test("table");
        cyc(2);
        chk_v("overflow latch", 11'h1, 11'(ovf));
        chk_v("timer load", 11'h0c5, 11'(tcnt));
        cyc(1);
        chk_v("skip", 11'h1, 11'(skip));
        chk_v("overflow latch", 11'h0, 11'(ovf));
        cyc(1);
        chk_v("skipped table load", 11'h00b, addr);
        cyc(1);
        chk_v("no skip", 11'h0, 11'(skip));
        end_test("timer");
        cyc(2);
        chk_v("indirect jump", 11'h0a7, addr);
        carry = 1'b1;
        cyc(1);
        chk_v("exchange acc", 11'h0, 11'(acc));
        chk_v("exchange serial", 11'h00c, 11'(ser));
        chk_v("clock latch", 11'h1, 11'(sclk));
        end_test("exchange");
        cyc(1);
        chk_st("idle state", SIE_IDLE, state);
        chk_v("serial shift", 11'h008, 11'(ser));
        chk_v("serial out", 11'h1, 11'(sout));
        n = 0;
        while (state === SIE_IDLE && n < 400) begin
            @(negedge clk);
            n++;
        end
        chk_v("idle address", 11'h0a9, addr);
        chk_v("wake overflow", 11'h1, 11'(ovf));
        chk_v("idle span", 11'h1, 11'(n > 100 && n < 400));
        end_test("idle");
        cyc(1);
        chk_v("page jump", 11'h0be, addr);
        cyc(2);
        chk_v("last word jump", 11'h0fe, addr);
        cyc(3);
        chk_v("group end jump", 11'h130, addr);
        end_test("pages");
        // Counter mode and event counting; no idle follows in event mode.
        cmode = 1'b1;
        tsel = 1'b1;
        sin = 1'b1;
        cyc(1);
        sin = 1'b0;
        tev = 1'b0;
        cyc(1);
        chk_v("serial count", 11'h001, 11'(ser));
        chk_v("event count", 11'h007, 11'(tcnt));
        end_test("counters");
        stop_test();
    end
endmodule

`default_nettype wire
